// ==== design/wake_match_params.svh ====
// Purpose: offsets, field positions and reset values of the wake bank
// Assumes: 16-bit registers, word-indexed offsets
// Notes: included by bare name
`ifndef WAKE_MATCH_PARAMS_SVH
`define WAKE_MATCH_PARAMS_SVH

`define WAKE_CONFIG_OFS 16'h04A0
`define WAKE_STATUS_OFS 16'h04A1
`define WAKE_DEST_ADDR_B4_B5_OFS 16'h04A2
`define WAKE_DEST_ADDR_B2_B3_OFS 16'h04A3
`define WAKE_DEST_ADDR_B0_B1_OFS 16'h04A4
`define WAKE_PASSWORD_B0_B1_OFS 16'h04A5
`define WAKE_PASSWORD_B2_B3_OFS 16'h04A6
`define WAKE_PASSWORD_B4_B5_OFS 16'h04A7
`define RX_PATTERN_B0_B1_OFS 16'h04A8
`define WAKE_MASK_OFS 16'h04B8

`define CFG_PASSWORD_EN_BIT 5
`define CFG_PATTERN_EN_BIT 1
`define CFG_RW_MASK 16'h0022
`define STAT_HACK_BIT 5
`define STAT_PATTERN_BIT 1
`define STAT_RW_MASK 16'h0022

`define BYTES_RESET 48'h0000_0000_0000
`define WORD_RESET 16'h0000
`define ADDR_BYTES 4'h6
`define PASSWORD_BYTES 3'h6
`define MIN_ADDR_WIDTH 11

`endif

// ==== design/wake_match_pkg.sv ====
// Purpose: carrier types of the wake match bank
// Assumes: byte stream from the receive path, one byte per valid
// Notes: byte k of each vector sits at bits [8k+7:8k]
package wake_match_pkg;

  typedef struct packed {
    logic valid;
    logic sof;
    logic last;
    logic pw;
    logic crc_ok;
    logic [7:0] data;
  } rx_byte_type;

  typedef struct packed {
    logic [47:0] dest_addr;
    logic [47:0] password;
    logic [15:0] pattern;
  } match_data_type;

  typedef struct packed {
    logic hack;
    logic pattern;
  } wake_event_type;

endpackage

// ==== design/wake_match_config_regs.sv ====
// Purpose: wake-on-frame match data bank with a small frame matcher
// Assumes: one clock, synchronous active high reset, synchronous inputs
// Notes: read data valid only in the cycle after the read strobe
//
// Overview of operation
// - Offset 0x04A2 holds address byte 4 high and byte 5 low, RW, reset 0.
// - Offset 0x04A3 holds address byte 2 high and byte 3 low, RW, reset 0.
// - Offset 0x04A4 holds address byte 0 high and byte 1 low, RW, reset 0.
// - The six address bytes are compared with each frame's destination.
// - Offset 0x04A5 holds password byte 1 high, byte 0 low, RW, reset 0.
// - Offsets 0x04A6 and 0x04A7 hold password bytes 3/2 and 5/4, reset 0.
// - The six password bytes are the expected password of a wake frame.
// - Offset 0x04A8 holds pattern byte 0 low and byte 1 high, RW, reset 0.
// - The password is checked only while the password enable bit 5 is set.
// - A wrong password latches status bit 5 until software clears it.
// - A valid frame with the pattern latches status bit 1.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`include "wake_match_params.svh"

module wake_match_config_regs #(
  parameter int ADDR_WIDTH = 16
) (
  // clock and control
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  // register port
  input wire logic [ADDR_WIDTH-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [15:0] o_rdata,
  // receive byte stream
  input wire wake_match_pkg::rx_byte_type i_rx,
  // stored match data and events
  output wake_match_pkg::match_data_type o_match,
  output wake_match_pkg::wake_event_type o_event,
  output logic o_irq
);

  if (ADDR_WIDTH < `MIN_ADDR_WIDTH) begin : g_check
    $error("ADDR_WIDTH too small for the register map");
  end

  wake_match_pkg::match_data_type live;
  wake_match_pkg::match_data_type snap;
  logic [15:0] config_reg;
  logic [15:0] status_reg;
  logic [15:0] mask_reg;
  logic [15:0] rdata;
  logic irq;
  wake_match_pkg::wake_event_type event_q;

  logic in_frame;
  logic [3:0] byte_idx;
  logic [2:0] pw_idx;
  logic da_ok;
  logic pat_ok;
  logic pw_ok;
  logic next_da_ok;
  logic next_pat_ok;
  logic next_pw_ok;
  logic [2:0] next_pw_idx;
  logic [3:0] cur_idx;
  logic frame_end;
  logic ev_hack;
  logic ev_pattern;
  logic [15:0] status_set;
  logic [15:0] status_clr;

  function automatic logic [7:0] byte_of(input logic [47:0] v,
                                         input logic [3:0] k);
    byte_of = v[{k[2:0], 3'h0} +: 8];
  endfunction

  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                               input logic [15:0] ofs);
    hit = (a == ADDR_WIDTH'(ofs));
  endfunction

  // register writes
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      live.dest_addr <= `BYTES_RESET;
      live.password <= `BYTES_RESET;
      live.pattern <= `WORD_RESET;
    end else if (i_enable && i_write) begin
      if (hit(i_addr, `WAKE_DEST_ADDR_B4_B5_OFS)) begin
        live.dest_addr[39:32] <= i_wdata[15:8];
        live.dest_addr[47:40] <= i_wdata[7:0];
      end
      if (hit(i_addr, `WAKE_DEST_ADDR_B2_B3_OFS)) begin
        live.dest_addr[23:16] <= i_wdata[15:8];
        live.dest_addr[31:24] <= i_wdata[7:0];
      end
      if (hit(i_addr, `WAKE_DEST_ADDR_B0_B1_OFS)) begin
        live.dest_addr[7:0] <= i_wdata[15:8];
        live.dest_addr[15:8] <= i_wdata[7:0];
      end
      if (hit(i_addr, `WAKE_PASSWORD_B0_B1_OFS)) begin
        live.password[15:0] <= i_wdata;
      end
      if (hit(i_addr, `WAKE_PASSWORD_B2_B3_OFS)) begin
        live.password[31:16] <= i_wdata;
      end
      if (hit(i_addr, `WAKE_PASSWORD_B4_B5_OFS)) begin
        live.password[47:32] <= i_wdata;
      end
      if (hit(i_addr, `RX_PATTERN_B0_B1_OFS)) begin
        live.pattern <= i_wdata;
      end
    end
  end

  // configuration and mask
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      config_reg <= `WORD_RESET;
      mask_reg <= `WORD_RESET;
    end else if (i_enable && i_write) begin
      if (hit(i_addr, `WAKE_CONFIG_OFS)) begin
        config_reg <= i_wdata & `CFG_RW_MASK;
      end
      if (hit(i_addr, `WAKE_MASK_OFS)) begin
        mask_reg <= i_wdata & `STAT_RW_MASK;
      end
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata <= `WORD_RESET;
    end else if (i_enable) begin
      rdata <= `WORD_RESET;
      if (i_read) begin
        case (1'b1)
          hit(i_addr, `WAKE_CONFIG_OFS): rdata <= config_reg;
          hit(i_addr, `WAKE_STATUS_OFS): rdata <= status_reg;
          hit(i_addr, `WAKE_MASK_OFS): rdata <= mask_reg;
          hit(i_addr, `WAKE_DEST_ADDR_B4_B5_OFS): begin
            rdata <= {live.dest_addr[39:32], live.dest_addr[47:40]};
          end
          hit(i_addr, `WAKE_DEST_ADDR_B2_B3_OFS): begin
            rdata <= {live.dest_addr[23:16], live.dest_addr[31:24]};
          end
          hit(i_addr, `WAKE_DEST_ADDR_B0_B1_OFS): begin
            rdata <= {live.dest_addr[7:0], live.dest_addr[15:8]};
          end
          hit(i_addr, `WAKE_PASSWORD_B0_B1_OFS): begin
            rdata <= live.password[15:0];
          end
          hit(i_addr, `WAKE_PASSWORD_B2_B3_OFS): begin
            rdata <= live.password[31:16];
          end
          hit(i_addr, `WAKE_PASSWORD_B4_B5_OFS): begin
            rdata <= live.password[47:32];
          end
          hit(i_addr, `RX_PATTERN_B0_B1_OFS): rdata <= live.pattern;
          default: rdata <= `WORD_RESET;
        endcase
      end
    end
  end

  // per-byte comparison, the start byte uses the live copy
  always_comb begin
    cur_idx = i_rx.sof ? 4'h0 : byte_idx;
    next_da_ok = i_rx.sof ? 1'b1 : da_ok;
    next_pat_ok = i_rx.sof ? 1'b1 : pat_ok;
    next_pw_ok = i_rx.sof ? 1'b1 : pw_ok;
    next_pw_idx = i_rx.sof ? 3'h0 : pw_idx;
    if (cur_idx < `ADDR_BYTES) begin
      next_da_ok = next_da_ok && (i_rx.data == byte_of(
        i_rx.sof ? live.dest_addr : snap.dest_addr, cur_idx));
    end
    if (cur_idx < 4'h2) begin
      next_pat_ok = next_pat_ok && (i_rx.data == byte_of(
        {32'h0000_0000, i_rx.sof ? live.pattern : snap.pattern}, cur_idx));
    end
    if (i_rx.pw && next_pw_idx < `PASSWORD_BYTES) begin
      next_pw_ok = next_pw_ok && (i_rx.data == byte_of(
        i_rx.sof ? live.password : snap.password,
        {1'b0, next_pw_idx}));
      next_pw_idx = next_pw_idx + 3'h1;
    end
  end

  assign frame_end = i_rx.valid && i_rx.last && (in_frame || i_rx.sof);

  // password fault: some password bytes seen, not all six right
  assign ev_hack = frame_end && i_rx.crc_ok && next_da_ok &&
    config_reg[`CFG_PASSWORD_EN_BIT] && (next_pw_idx != 3'h0) &&
    !(next_pw_ok && next_pw_idx == `PASSWORD_BYTES);
  assign ev_pattern = frame_end && i_rx.crc_ok && next_da_ok &&
    config_reg[`CFG_PATTERN_EN_BIT] && next_pat_ok;

  // frame tracking and snapshot of the match data
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      in_frame <= 1'b0;
      byte_idx <= 4'h0;
      pw_idx <= 3'h0;
      da_ok <= 1'b0;
      pat_ok <= 1'b0;
      pw_ok <= 1'b0;
      snap <= '0;
    end else if (i_enable && i_rx.valid) begin
      if (i_rx.sof) begin
        snap <= live;
      end
      if (i_rx.sof || in_frame) begin
        in_frame <= !i_rx.last;
        byte_idx <= (cur_idx == 4'hF) ? 4'hF : cur_idx + 4'h1;
        pw_idx <= next_pw_idx;
        da_ok <= next_da_ok;
        pat_ok <= next_pat_ok;
        pw_ok <= next_pw_ok;
      end
    end
  end

  // sticky status, set wins over a write-one clear
  always_comb begin
    status_set = `WORD_RESET;
    status_set[`STAT_HACK_BIT] = ev_hack;
    status_set[`STAT_PATTERN_BIT] = ev_pattern;
    status_clr = `WORD_RESET;
    if (i_write && hit(i_addr, `WAKE_STATUS_OFS)) begin
      status_clr = i_wdata & `STAT_RW_MASK;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      status_reg <= `WORD_RESET;
    end else if (i_enable) begin
      status_reg <= (status_reg & ~status_clr) | status_set;
    end
  end

  // interrupt and event pulses
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq <= 1'b0;
      event_q <= '0;
    end else if (i_enable) begin
      irq <= |(status_reg & mask_reg);
      event_q.hack <= ev_hack;
      event_q.pattern <= ev_pattern;
    end
  end

  assign o_rdata = rdata;
  assign o_match = live;
  assign o_event = event_q;
  assign o_irq = irq;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  AST_DA45_READBACK: assert property (
    i_enable && i_write && hit(i_addr, `WAKE_DEST_ADDR_B4_B5_OFS) ##1
    i_enable && i_read && hit(i_addr, `WAKE_DEST_ADDR_B4_B5_OFS) ##1
    i_enable |-> o_rdata == $past(i_wdata, 2))
    else $error("address bytes 4/5 readback wrong");

  AST_DA45_STORE: assert property (
    i_enable && i_write && hit(i_addr, `WAKE_DEST_ADDR_B4_B5_OFS) |=>
    o_match.dest_addr[39:32] == $past(i_wdata[15:8]) &&
    o_match.dest_addr[47:40] == $past(i_wdata[7:0]))
    else $error("address bytes 4/5 not stored");

  AST_DA23_STORE: assert property (
    i_enable && i_write && hit(i_addr, `WAKE_DEST_ADDR_B2_B3_OFS) |=>
    o_match.dest_addr[23:16] == $past(i_wdata[15:8]) &&
    o_match.dest_addr[31:24] == $past(i_wdata[7:0]))
    else $error("address bytes 2/3 not stored");

  AST_DA01_STORE: assert property (
    i_enable && i_write && hit(i_addr, `WAKE_DEST_ADDR_B0_B1_OFS) |=>
    o_match.dest_addr[7:0] == $past(i_wdata[15:8]) &&
    o_match.dest_addr[15:8] == $past(i_wdata[7:0]))
    else $error("address bytes 0/1 not stored");

  AST_PW_STORE: assert property (
    i_enable && i_write && hit(i_addr, `WAKE_PASSWORD_B0_B1_OFS) |=>
    o_match.password[15:0] == $past(i_wdata))
    else $error("password bytes 0/1 not stored");

  AST_PW23_STORE: assert property (
    i_enable && i_write && hit(i_addr, `WAKE_PASSWORD_B2_B3_OFS) |=>
    o_match.password[31:16] == $past(i_wdata))
    else $error("password bytes 2/3 not stored");

  AST_PW45_STORE: assert property (
    i_enable && i_write && hit(i_addr, `WAKE_PASSWORD_B4_B5_OFS) |=>
    o_match.password[47:32] == $past(i_wdata))
    else $error("password bytes 4/5 not stored");

  AST_PAT_STORE: assert property (
    i_enable && i_write && hit(i_addr, `RX_PATTERN_B0_B1_OFS) |=>
    o_match.pattern == $past(i_wdata))
    else $error("pattern bytes not stored");

  AST_HOLD_DATA: assert property (
    !(i_enable && i_write) |=> $stable(o_match))
    else $error("match data changed without a write");

  AST_NO_PW_CHECK: assert property (
    i_enable && !config_reg[`CFG_PASSWORD_EN_BIT] |=> !o_event.hack)
    else $error("password checked while disabled");

  AST_HACK_STICKY: assert property (
    i_enable && ev_hack |=> status_reg[`STAT_HACK_BIT] && o_event.hack)
    else $error("hack flag not latched");

  AST_HACK_HOLD: assert property (
    status_reg[`STAT_HACK_BIT] && !(i_enable && i_write &&
    hit(i_addr, `WAKE_STATUS_OFS) && i_wdata[`STAT_HACK_BIT]) |=>
    status_reg[`STAT_HACK_BIT])
    else $error("hack flag lost without a clear");

  AST_PATTERN_FLAG: assert property (
    i_enable && ev_pattern |=> status_reg[`STAT_PATTERN_BIT] &&
    o_event.pattern)
    else $error("pattern flag not set");

  AST_NO_EVENT_IDLE: assert property (
    i_enable && !i_rx.valid |=> !o_event.hack && !o_event.pattern)
    else $error("event without a frame byte");

  AST_IRQ_LEVEL: assert property (
    i_enable |=> o_irq == |($past(status_reg) & $past(mask_reg)))
    else $error("interrupt level wrong");

  AST_READ_ONE_CYCLE: assert property (
    i_enable && !i_read |=> o_rdata == `WORD_RESET)
    else $error("read data outside its cycle");

  COV_HACK: cover property (ev_hack ##[1:4] o_irq);
  COV_PATTERN: cover property (ev_pattern);
  COV_CLEAR: cover property (
    status_reg[`STAT_PATTERN_BIT] ##1 !status_reg[`STAT_PATTERN_BIT]);
  COV_SET_CLEAR: cover property (ev_hack && status_clr[`STAT_HACK_BIT]);

endmodule

// ==== bench/wake_match_config_regs_tb.sv ====
// Purpose: self-checking bench for the wake match data bank
// Assumes: one 125 MHz clock, synchronous reset, inputs driven at posedge
// Notes: each scenario is a task that drives and judges on its own
`timescale 1ns/1ns
`include "wake_match_params.svh"

module wake_match_config_regs_tb;
  logic i_clock;
  logic i_reset;
  logic i_enable;
  logic i_write;
  logic i_read;
  logic [15:0] i_addr;
  logic [15:0] i_wdata;
  logic [15:0] o_rdata;
  logic o_irq;
  wake_match_pkg::rx_byte_type i_rx;
  wake_match_pkg::match_data_type o_match;
  wake_match_pkg::wake_event_type o_event;
  int error_cnt = 0;
  int checks_done = 0;
  logic [47:0] dest = 48'h6655_4433_2211;
  logic [47:0] pass = 48'hC6C5_C4C3_C2C1;
  logic [1:0] ev;
  logic [1:0] ev2;
  logic irq;

  wake_match_config_regs #(.ADDR_WIDTH(16)) dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
    .i_read(i_read), .o_rdata(o_rdata), .i_rx(i_rx),
    .o_match(o_match), .o_event(o_event), .o_irq(o_irq));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] exp,
                     input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // write strobe left high: the next rdchk or send lowers it
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    i_write <= 1'b1;
    i_read <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    i_read <= 1'b1;
    i_write <= 1'b0;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 chk("rdata", {32'h0, exp}, {32'h0, o_rdata});
    @(posedge i_clock);
  endtask

  task automatic load_bank(input logic [47:0] d, input logic [47:0] p,
                           input logic [15:0] pat);
    wr(`WAKE_DEST_ADDR_B4_B5_OFS, {d[39:32], d[47:40]});
    wr(`WAKE_DEST_ADDR_B2_B3_OFS, {d[23:16], d[31:24]});
    wr(`WAKE_DEST_ADDR_B0_B1_OFS, {d[7:0], d[15:8]});
    wr(`WAKE_PASSWORD_B0_B1_OFS, p[15:0]);
    wr(`WAKE_PASSWORD_B2_B3_OFS, p[31:16]);
    wr(`WAKE_PASSWORD_B4_B5_OFS, p[47:32]);
    wr(`RX_PATTERN_B0_B1_OFS, pat);
  endtask

  // six address bytes, then six password bytes when npw is set
  task automatic send(input logic [47:0] d, input logic [47:0] p,
                      input logic npw);
    int n;
    n = npw ? 12 : 6;
    for (int k = 0; k < n; k++) begin
      i_write <= 1'b0;
      i_rx <= '{valid: 1'b1, sof: k == 0, last: k == n - 1, pw: k >= 6,
                crc_ok: 1'b1, data: k < 6 ? d[8*k +: 8] : p[8*(k-6) +: 8]};
      @(posedge i_clock);
    end
    i_rx <= '0;
    #1 ev = o_event;
    @(posedge i_clock);
    #1 irq = o_irq;
    ev2 = o_event;
    @(posedge i_clock);
  endtask

  task automatic t_reset();
    rdchk(`WAKE_DEST_ADDR_B4_B5_OFS, 16'h0000);
    rdchk(`WAKE_DEST_ADDR_B2_B3_OFS, 16'h0000);
    rdchk(`WAKE_DEST_ADDR_B0_B1_OFS, 16'h0000);
    rdchk(`WAKE_PASSWORD_B0_B1_OFS, 16'h0000);
    rdchk(`WAKE_PASSWORD_B2_B3_OFS, 16'h0000);
    rdchk(`WAKE_PASSWORD_B4_B5_OFS, 16'h0000);
    rdchk(`RX_PATTERN_B0_B1_OFS, 16'h0000);
    chk("match", 48'h0, o_match.dest_addr | o_match.password);
  endtask

  task automatic t_regs();
    i_enable <= 1'b0;
    wr(`RX_PATTERN_B0_B1_OFS, 16'hFFFF);
    i_enable <= 1'b1;
    rdchk(`RX_PATTERN_B0_B1_OFS, 16'h0000);
    load_bank(dest, pass, 16'hB1B0);
    wr(`WAKE_DEST_ADDR_B4_B5_OFS, 16'h5566);
    rdchk(`WAKE_DEST_ADDR_B4_B5_OFS, 16'h5566);
    rdchk(`WAKE_DEST_ADDR_B2_B3_OFS, 16'h3344);
    rdchk(`WAKE_DEST_ADDR_B0_B1_OFS, 16'h1122);
    rdchk(`WAKE_PASSWORD_B0_B1_OFS, 16'hC2C1);
    rdchk(`WAKE_PASSWORD_B2_B3_OFS, 16'hC4C3);
    rdchk(`WAKE_PASSWORD_B4_B5_OFS, 16'hC6C5);
    rdchk(`RX_PATTERN_B0_B1_OFS, 16'hB1B0);
    chk("dest", dest, o_match.dest_addr);
    chk("password", pass, o_match.password);
    chk("pattern", 48'hB1B0, {32'h0, o_match.pattern});
    wr(16'h04B0, 16'hA5A5);
    rdchk(16'h04B0, 16'h0000);
  endtask

  task automatic t_pattern();
    load_bank(dest, pass, dest[15:0]);
    wr(`WAKE_CONFIG_OFS, 16'h0002);
    wr(`WAKE_MASK_OFS, 16'h0002);
    send(dest, pass, 1'b0);
    chk("pattern event", 48'h1, {46'h0, ev});
    chk("event width", 48'h0, {46'h0, ev2});
    chk("irq", 48'h1, {47'h0, irq});
    rdchk(`WAKE_STATUS_OFS, 16'h0002);
    wr(`WAKE_STATUS_OFS, 16'h0002);
    rdchk(`WAKE_STATUS_OFS, 16'h0000);
    send(dest ^ 48'h0100_0000_0000, pass, 1'b0);
    chk("address miss", 48'h0, {46'h0, ev});
    chk("dest kept", dest, o_match.dest_addr);
    wr(`RX_PATTERN_B0_B1_OFS, 16'h2212);
    send(dest, pass, 1'b0);
    chk("pattern miss", 48'h0, {46'h0, ev});
  endtask

  task automatic t_password();
    wr(`WAKE_CONFIG_OFS, 16'h0020);
    wr(`WAKE_MASK_OFS, 16'h0020);
    send(dest, pass ^ 48'h0000_0100_0000, 1'b1);
    chk("hack event", 48'h1, {47'h0, ev[1]});
    chk("hack irq", 48'h1, {47'h0, irq});
    rdchk(`WAKE_STATUS_OFS, 16'h0020);
    wr(`WAKE_STATUS_OFS, 16'h0020);
    send(dest, pass, 1'b1);
    chk("good password", 48'h0, {47'h0, ev[1]});
    chk("irq cleared", 48'h0, {47'h0, irq});
    wr(`WAKE_CONFIG_OFS, 16'h0000);
    send(dest, ~pass, 1'b1);
    chk("check disabled", 48'h0, {47'h0, ev[1]});
    chk("password kept", pass, o_match.password);
  endtask

  initial begin
    repeat (5000) @(posedge i_clock);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    i_reset = 1'b1;
    i_enable = 1'b1;
    i_write = 1'b0;
    i_read = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 16'h0000;
    i_rx = '0;
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    t_reset();
    t_regs();
    t_pattern();
    t_password();
    report_and_stop();
  end
endmodule
